// ### logic/sid_pkg.sv
// constants for the two-channel interrupt daisy chain block
package sid_pkg;
    localparam int NUM_CH     = 2;
    localparam int SRC_PER_CH = 3;
    localparam int NUM_SRC    = 6;
    localparam int SRC_RX     = 0;
    localparam int SRC_TX     = 1;
    localparam int SRC_EXT    = 2;
    // register port
    localparam int ADDR_W      = 5;
    localparam int ADDR_CH_BIT = 4;
    localparam int DATA_W      = 8;
    localparam logic [3:0] REG_COMMAND    = 4'h0;
    localparam logic [3:0] REG_XFER_MODE  = 4'h1;
    localparam logic [3:0] REG_VECTOR     = 4'h2;
    localparam logic [3:0] REG_PENDING    = 4'h3;
    localparam logic [3:0] REG_MASTER     = 4'h9;
    localparam logic [3:0] REG_EXT_ENABLE = 4'hF;
    // command field of the command register
    localparam int CMD_LSB = 3;
    localparam int CMD_W   = 3;
    localparam logic [2:0] CMD_RESET_EXT = 3'h2;
    localparam logic [2:0] CMD_RX_NEXT   = 3'h4;
    localparam logic [2:0] CMD_RESET_TX  = 3'h5;
    localparam logic [2:0] CMD_RESET_IUS = 3'h7;
    // master control bits
    localparam int MIC_VIS   = 0;
    localparam int MIC_NV    = 1;
    localparam int MIC_MIE   = 3;
    localparam int MIC_SWACK = 5;
    // transfer mode bits
    localparam int XM_EXT_EN = 0;
    localparam int XM_TX_EN  = 1;
    localparam int XM_RX_LSB = 3;
    localparam int XM_WR_RX  = 5;
    localparam int XM_WR_REQ = 6;
    localparam int XM_WR_EN  = 7;
    // external/status enable bits
    localparam int EE_ZERO  = 1;
    localparam int EE_DCD   = 3;
    localparam int EE_SYNC  = 4;
    localparam int EE_CTS   = 5;
    localparam int EE_UNDER = 6;
    localparam int EE_BREAK = 7;
    localparam logic [7:0] RST_EXT_EN = 8'hF8;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    // vector status code position and values
    localparam int VEC_CODE_LSB = 1;
    localparam int VEC_CODE_W   = 3;
    localparam logic [2:0] CODE_B_TX   = 3'h0;
    localparam logic [2:0] CODE_B_EXT  = 3'h1;
    localparam logic [2:0] CODE_B_RX   = 3'h2;
    localparam logic [2:0] CODE_B_SPEC = 3'h3;
    localparam logic [2:0] CODE_A_TX   = 3'h4;
    localparam logic [2:0] CODE_A_EXT  = 3'h5;
    localparam logic [2:0] CODE_A_RX   = 3'h6;
    localparam logic [2:0] CODE_A_SPEC = 3'h7;
    localparam logic [2:0] CODE_NONE   = 3'h3;
    // pending summary bit of each source
    localparam int PEND_BIT [NUM_SRC] = '{5, 4, 3, 2, 1, 0};
    typedef enum logic [1:0] {
        RXM_OFF     = 2'h0,
        RXM_FIRST   = 2'h1,
        RXM_ALL     = 2'h2,
        RXM_SPECIAL = 2'h3
    } sid_rx_mode_type;
endpackage

// ### logic/sid_irq_chain.sv
// interrupt priority chain, acknowledge, vector and wait/request logic
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps

module sid_irq_chain (
    input  wire logic                        clk_in,
    input  wire logic                        reset_n_in,
    input  wire logic [sid_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [sid_pkg::DATA_W-1:0]  wr_data_in,
    input  wire logic                        wr_strobe_in,
    input  wire logic                        rd_strobe_in,
    output logic      [sid_pkg::DATA_W-1:0]  rd_data_out,
    input  wire logic                        irq_acknowledge_n_in,
    input  wire logic                        ack_read_in,
    input  wire logic                        chain_enable_in,
    output logic                             chain_enable_out,
    output logic                             int_n_out,
    output logic                             int_oe_out,
    output logic      [sid_pkg::DATA_W-1:0]  vector_bus_out,
    output logic                             vector_oe_out,
    input  wire logic [sid_pkg::NUM_CH-1:0]  rx_char_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  rx_special_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  rx_char_taken_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  tx_empty_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  cts_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  carrier_detect_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  sync_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  break_abort_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  tx_underrun_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  brg_zero_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  rx_ready_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  tx_ready_in,
    input  wire logic [sid_pkg::NUM_CH-1:0]  data_access_in,
    output logic      [sid_pkg::NUM_CH-1:0]  wait_req_out,
    output logic      [sid_pkg::NUM_CH-1:0]  wait_req_oe_out
);
    import sid_pkg::*;

    // lowest set bit wins, lowest index is highest priority
    function automatic logic [NUM_SRC-1:0] first_one(input logic [NUM_SRC-1:0] v);
        first_one = v & (~v + 6'h01);
    endfunction

    // bit i set when any bit at or above priority i is set
    function automatic logic [NUM_SRC-1:0] prefix_or(input logic [NUM_SRC-1:0] v);
        logic acc;
        acc = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            acc = acc | v[i];
            prefix_or[i] = acc;
        end
    endfunction

    // three-bit source code of a one-hot selection
    function automatic logic [2:0] src_code(input logic [NUM_SRC-1:0] s,
                                            input logic [NUM_CH-1:0]  spec);
        if (s[SRC_RX])
            src_code = spec[0] ? CODE_A_SPEC : CODE_A_RX;
        else if (s[SRC_TX])
            src_code = CODE_A_TX;
        else if (s[SRC_EXT])
            src_code = CODE_A_EXT;
        else if (s[SRC_PER_CH+SRC_RX])
            src_code = spec[1] ? CODE_B_SPEC : CODE_B_RX;
        else if (s[SRC_PER_CH+SRC_TX])
            src_code = CODE_B_TX;
        else if (s[SRC_PER_CH+SRC_EXT])
            src_code = CODE_B_EXT;
        else
            src_code = CODE_NONE;
    endfunction

    logic [7:0]         xfer_mode [NUM_CH];
    logic [7:0]         ext_en [NUM_CH];
    logic [7:0]         vector_reg;
    logic [7:0]         master_reg;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] under_service;
    logic [NUM_SRC-1:0] ack_owner;
    logic [NUM_CH-1:0]  rx_seen;
    logic [NUM_CH-1:0]  rx_spec;
    logic [NUM_CH-1:0]  cts_prev;
    logic [NUM_CH-1:0]  dcd_prev;
    logic [NUM_CH-1:0]  sync_prev;
    logic [NUM_CH-1:0]  brk_prev;
    logic               ack_q;
    logic               ack_d;
    logic               ack_won;

    // register port decode
    wire [3:0] addr_idx = addr_in[3:0];
    wire       ch_sel   = addr_in[ADDR_CH_BIT];
    wire       wr_cmd   = wr_strobe_in & (addr_idx == REG_COMMAND);
    wire       wr_xfer  = wr_strobe_in & (addr_idx == REG_XFER_MODE);
    wire       wr_vec   = wr_strobe_in & (addr_idx == REG_VECTOR);
    wire       wr_mast  = wr_strobe_in & (addr_idx == REG_MASTER);
    wire       wr_ext   = wr_strobe_in & (addr_idx == REG_EXT_ENABLE);
    wire       rd_vec   = rd_strobe_in & (addr_idx == REG_VECTOR);
    wire [2:0] cmd_code = wr_data_in[CMD_LSB +: CMD_W];

    // master control fields
    wire global_irq_enable      = master_reg[MIC_MIE];
    wire swack_en = master_reg[MIC_SWACK];
    wire vis_eff  = master_reg[MIC_VIS] & ~swack_en;
    wire nv_eff   = master_reg[MIC_NV] & ~swack_en;

    // per-source enable, raise and clear terms
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] raise;
    logic [NUM_SRC-1:0] clr;
    logic [NUM_CH-1:0]  next_rx_seen;
    logic [NUM_CH-1:0]  next_rx_spec;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int B = c * SRC_PER_CH;
        wire [1:0] rx_mode = xfer_mode[c][XM_RX_LSB +: 2];
        wire [7:0] ee      = ext_en[c];
        wire       cmd_ch  = wr_cmd & (ch_sel == 1'(c));
        wire       m_first = rx_mode == RXM_FIRST;
        wire       m_all   = rx_mode == RXM_ALL;
        wire       m_spec  = rx_mode == RXM_SPECIAL;
        wire rx_chr = rx_char_in[c] & (m_all | (m_first & ~rx_seen[c]));
        wire rx_spc = rx_special_in[c] & (m_all | m_spec | (m_first & rx_seen[c]));
        wire ext_evt = (ee[EE_CTS] & (cts_in[c] ^ cts_prev[c]))
                     | (ee[EE_DCD] & (carrier_detect_in[c] ^ dcd_prev[c]))
                     | (ee[EE_SYNC] & (sync_in[c] ^ sync_prev[c]))
                     // both edges of abort or end of poll
                     | (ee[EE_BREAK] & (break_abort_in[c] ^ brk_prev[c]))
                     | (ee[EE_UNDER] & tx_underrun_in[c])
                     | (ee[EE_ZERO] & brg_zero_in[c]);

        assign src_en[B+SRC_RX]  = rx_mode != RXM_OFF;
        assign src_en[B+SRC_TX]  = xfer_mode[c][XM_TX_EN];
        assign src_en[B+SRC_EXT] = xfer_mode[c][XM_EXT_EN];
        assign raise[B+SRC_RX]   = rx_chr | rx_spc;
        assign raise[B+SRC_TX]   = tx_empty_in[c];
        assign raise[B+SRC_EXT]  = ext_evt;
        assign clr[B+SRC_RX]     = rx_char_taken_in[c];
        assign clr[B+SRC_TX]     = cmd_ch & (cmd_code == CMD_RESET_TX);
        assign clr[B+SRC_EXT]    = cmd_ch & (cmd_code == CMD_RESET_EXT);
        // first char flag rearmed by command or mode off
        assign next_rx_seen[c] = m_first & (rx_chr
                               | (rx_seen[c] & ~(cmd_ch & (cmd_code == CMD_RX_NEXT))));
        // special flag follows the receive pending bit
        assign next_rx_spec[c] = src_en[B+SRC_RX] & (rx_spc
                               | (rx_spec[c] & ~clr[B+SRC_RX] & ~rx_chr));
    end

    // pending kept only while enabled, set beats clear
    wire [NUM_SRC-1:0] next_pending = src_en & (raise | (pending & ~clr));

    wire [NUM_SRC-1:0] req = pending & src_en & {NUM_SRC{global_irq_enable}};

    // under service blocks equal and lower
    wire [NUM_SRC-1:0] eligible = req & ~prefix_or(under_service);
    wire [NUM_SRC-1:0] winner   = first_one(eligible);
    wire               any_elig = |eligible;

    // acknowledge start, hardware or software
    wire hw_ack_start = ack_q & ~ack_d;
    wire sw_ack       = rd_vec & swack_en;
    wire ack_fire     = (hw_ack_start | sw_ack) & chain_enable_in;
    wire [NUM_SRC-1:0] ack_set = ack_fire ? winner : '0;
    // host command frees the highest under-service bit
    wire ius_reset    = wr_cmd & (cmd_code == CMD_RESET_IUS);
    wire [NUM_SRC-1:0] ius_clr = ius_reset ? first_one(under_service) : '0;
    wire [NUM_SRC-1:0] next_ius = (under_service & ~ius_clr) | ack_set;

    // vector values
    // acknowledge edge loads the winner's code, so a driven bus never shows a stale vector
    wire [2:0] owner_code = src_code(ack_fire ? winner : ack_owner, rx_spec);
    wire [2:0] win_code   = src_code(first_one(req & ~prefix_or(under_service)), rx_spec);
    // status code replaces three vector bits
    wire [7:0] vec_mod_hw = {vector_reg[7:VEC_CODE_LSB+VEC_CODE_W], owner_code,
                             vector_reg[VEC_CODE_LSB-1:0]};
    wire [7:0] vec_mod_rd = {vector_reg[7:VEC_CODE_LSB+VEC_CODE_W], win_code,
                             vector_reg[VEC_CODE_LSB-1:0]};
    wire [7:0] vec_hw     = vis_eff ? vec_mod_hw : vector_reg;

    // pending summary for channel A reads
    logic [7:0] pend_summary;
    assign pend_summary[7:NUM_SRC] = '0;
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_ps
        assign pend_summary[PEND_BIT[i]] = pending[i];
    end

    // read mux; enables and modes are not readable
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RST_ZERO;
        unique case (addr_idx)
            REG_COMMAND: rd_mux = {2'h0, under_service};
            REG_VECTOR:  rd_mux = ch_sel ? vec_mod_rd : vector_reg;
            REG_PENDING: rd_mux = ch_sel ? RST_ZERO : pend_summary;
            default:     rd_mux = RST_ZERO;
        endcase
    end

    wire int_active = chain_enable_in & any_elig & ~ack_q;
    assign int_n_out  = 1'b0;
    assign int_oe_out = int_active;

    assign chain_enable_out = chain_enable_in & ~(|req) & ~(|under_service);

    // vector onto bus while read is active
    assign vector_oe_out = ack_q & ack_read_in & chain_enable_in & ack_won & ~nv_eff;

    // wait/request pins per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_wr
        wire en    = xfer_mode[c][XM_WR_EN];
        wire ready = xfer_mode[c][XM_WR_RX] ? rx_ready_in[c] : tx_ready_in[c];
        wire dma   = xfer_mode[c][XM_WR_REQ];
        // request driven both ways, wait open drain
        assign wait_req_out[c]    = dma ? ~(en & ready) : 1'b0;
        assign wait_req_oe_out[c] = dma | (en & ~ready & data_access_in[c]);
    end

    // host written registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int c = 0; c < NUM_CH; c++) begin
                xfer_mode[c] <= RST_ZERO;
                ext_en[c]    <= RST_EXT_EN;
            end
            vector_reg <= RST_ZERO;
            master_reg <= RST_ZERO;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (wr_xfer && ch_sel == 1'(c))
                    xfer_mode[c] <= wr_data_in;
                if (wr_ext && ch_sel == 1'(c))
                    ext_en[c] <= wr_data_in;
            end
            // shared by both channels
            if (wr_vec)
                vector_reg <= wr_data_in;
            if (wr_mast)
                master_reg <= wr_data_in;
        end
    end

    // interrupt state bits and input history
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pending       <= '0;
            under_service <= '0;
            rx_seen       <= '0;
            rx_spec       <= '0;
            cts_prev      <= '0;
            dcd_prev      <= '0;
            sync_prev     <= '0;
            brk_prev      <= '0;
        end else begin
            pending       <= next_pending;
            under_service <= next_ius;
            rx_seen       <= next_rx_seen;
            rx_spec       <= next_rx_spec;
            cts_prev      <= cts_in;
            dcd_prev      <= carrier_detect_in;
            sync_prev     <= sync_in;
            brk_prev      <= break_abort_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_q     <= 1'b0;
            ack_d     <= 1'b0;
            ack_won   <= 1'b0;
            ack_owner <= '0;
        end else begin
            ack_q <= ~irq_acknowledge_n_in;
            ack_d <= ack_q;
            if (hw_ack_start)
                ack_won <= chain_enable_in & any_elig;
            else if (!ack_q)
                ack_won <= 1'b0;
            if (ack_fire)
                ack_owner <= winner;
        end
    end

    // registered data outputs; read data valid one cycle only
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out    <= RST_ZERO;
            vector_bus_out <= RST_ZERO;
        end else begin
            rd_data_out    <= rd_strobe_in ? rd_mux : RST_ZERO;
            vector_bus_out <= vec_hw;
        end
    end
endmodule

// ### testbench/sid_irq_chain_properties.sv
// port assertions for the interrupt chain block
`timescale 1ns/10ps
module sid_irq_chain_chk
    import sid_pkg::*;
(
    input wire logic                       clk_in,
    input wire logic                       reset_n_in,
    input wire logic [sid_pkg::ADDR_W-1:0] addr_in,
    input wire logic                       rd_strobe_in,
    input wire logic [sid_pkg::DATA_W-1:0] rd_data_out,
    input wire logic                       irq_acknowledge_n_in,
    input wire logic                       ack_read_in,
    input wire logic                       chain_enable_in,
    input wire logic                       chain_enable_out,
    input wire logic                       int_oe_out,
    input wire logic                       vector_oe_out,
    input wire logic [sid_pkg::NUM_CH-1:0] wait_req_out,
    input wire logic [sid_pkg::NUM_CH-1:0] wait_req_oe_out
);
    // one clock domain, so clock and reset are declared once
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_int_needs_chain;
        !chain_enable_in |-> !int_oe_out;
    endproperty
    a_int_needs_chain: assert property (p_int_needs_chain) else $error("request while chain input low");
    property p_int_lowers_chain;
        int_oe_out |-> !chain_enable_out;
    endproperty
    a_int_lowers_chain: assert property (p_int_lowers_chain) else $error("chain out high while requesting");
    property p_chain_needs_in;
        chain_enable_out |-> chain_enable_in;
    endproperty
    a_chain_needs_in: assert property (p_chain_needs_in) else $error("chain out high with chain in low");
    property p_ack_releases;
        !irq_acknowledge_n_in |=> !int_oe_out;
    endproperty
    a_ack_releases: assert property (p_ack_releases) else $error("request held during acknowledge");
    property p_vector_drive;
        vector_oe_out |-> ack_read_in && chain_enable_in && !$past(irq_acknowledge_n_in);
    endproperty
    a_vector_drive: assert property (p_vector_drive) else $error("vector driven outside acknowledge read");
    property p_enable_hidden;
        rd_strobe_in && (addr_in[3:0] == REG_XFER_MODE || addr_in[3:0] == REG_EXT_ENABLE) |=> rd_data_out == 8'h00;
    endproperty
    a_enable_hidden: assert property (p_enable_hidden) else $error("enable bits readable");
    property p_pending_b_zero;
        rd_strobe_in && addr_in == {1'b1, REG_PENDING} |=> rd_data_out == 8'h00;
    endproperty
    a_pending_b_zero: assert property (p_pending_b_zero) else $error("pending summary seen through b");
    property p_wait_after_reset;
        !$past(reset_n_in) |-> wait_req_oe_out == 2'h0 && wait_req_out == 2'h0;
    endproperty
    a_wait_after_reset: assert property (p_wait_after_reset) else $error("wait pin not idle after reset");
endmodule

bind sid_irq_chain sid_irq_chain_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .irq_acknowledge_n_in(irq_acknowledge_n_in),
    .ack_read_in(ack_read_in), .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .int_oe_out(int_oe_out), .vector_oe_out(vector_oe_out), .wait_req_out(wait_req_out),
    .wait_req_oe_out(wait_req_oe_out));

// ### testbench/sid_host_model.sv
// host cpu model: acknowledge cycles and the shared bus wires
`timescale 1ns/10ps
module sid_host_model
    import sid_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       int_n_in,
    input  wire logic                       int_oe_in,
    input  wire logic [sid_pkg::DATA_W-1:0] vector_bus_in,
    input  wire logic                       vector_oe_in,
    output logic                            ack_n_out,
    output logic                            ack_read_out,
    output logic                            int_line_out,
    output logic [sid_pkg::DATA_W-1:0]      data_bus_out
);
    logic [DATA_W-1:0] last_bus;

    initial begin
        ack_n_out = 1'b1;
        ack_read_out = 1'b0;
        last_bus = 8'h00;
    end
    // open-drain request line sits on a pull-up
    assign int_line_out = int_oe_in ? int_n_in : 1'b1;
    // released bus shows inverted old data so a stale vector cannot pass
    assign data_bus_out = vector_oe_in ? vector_bus_in : ~last_bus;
    always @(posedge clk_in) begin
        if (vector_oe_in) begin
            last_bus <= vector_bus_in;
        end
    end
    // acknowledge and read held from edge to sampling edge
    task automatic do_ack(input int slow, output logic [DATA_W-1:0] vec);
        @(posedge clk_in);
        ack_n_out <= 1'b0;
        ack_read_out <= 1'b1;
        repeat (4 + slow) @(posedge clk_in);
        vec = data_bus_out;
        ack_n_out <= 1'b1;
        ack_read_out <= 1'b0;
    endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the interrupt chain block
`timescale 1ns/10ps
module tb;
    import sid_pkg::*;
    logic              clk_in = 1'b0;
    logic              reset_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wr_data_in = '0;
    logic              wr_strobe_in = 1'b0;
    logic              rd_strobe_in = 1'b0;
    logic              chain_enable_in = 1'b1;
    logic [NUM_CH-1:0] ev [6] = '{default: '0};
    logic [NUM_CH-1:0] lv [4] = '{default: '0};
    logic [NUM_CH-1:0] tx_ready_in = '0;
    logic [NUM_CH-1:0] rx_ready_in = '0;
    logic [NUM_CH-1:0] data_access_in = '0;
    logic [DATA_W-1:0] rd_data_out, vector_bus_out, data_bus, got;
    logic [NUM_CH-1:0] wait_req_out, wait_req_oe_out;
    logic              ack_n, ack_read, int_n_out, int_oe_out, int_line, vector_oe_out, chain_enable_out;
    int                num_errors = 0;
    int                n_checks = 0;

    always #12.5 clk_in = ~clk_in;

    sid_irq_chain u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
        .irq_acknowledge_n_in(ack_n), .ack_read_in(ack_read), .chain_enable_in(chain_enable_in),
        .chain_enable_out(chain_enable_out), .int_n_out(int_n_out), .int_oe_out(int_oe_out),
        .vector_bus_out(vector_bus_out), .vector_oe_out(vector_oe_out), .rx_char_in(ev[0]),
        .rx_special_in(ev[1]), .rx_char_taken_in(ev[2]), .tx_empty_in(ev[3]), .cts_in(lv[0]),
        .carrier_detect_in(lv[1]), .sync_in(lv[2]), .break_abort_in(lv[3]), .tx_underrun_in(ev[4]),
        .brg_zero_in(ev[5]), .rx_ready_in(rx_ready_in), .tx_ready_in(tx_ready_in),
        .data_access_in(data_access_in),
        .wait_req_out(wait_req_out), .wait_req_oe_out(wait_req_oe_out));
    sid_host_model u_host (.clk_in(clk_in), .int_n_in(int_n_out), .int_oe_in(int_oe_out),
        .vector_bus_in(vector_bus_out), .vector_oe_in(vector_oe_out), .ack_n_out(ack_n),
        .ack_read_out(ack_read), .int_line_out(int_line), .data_bus_out(data_bus));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // register write: one strobe cycle, settled on return
    task automatic wr(input logic ch, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        wr_strobe_in <= 1'b1;
        addr_in <= {ch, idx};
        wr_data_in <= d;
        @(posedge clk_in);
        wr_strobe_in <= 1'b0;
        #1;
    endtask
    // register read: data stands only in the cycle after the strobe
    task automatic rd(input logic ch, input logic [3:0] idx, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        rd_strobe_in <= 1'b1;
        addr_in <= {ch, idx};
        @(posedge clk_in);
        rd_strobe_in <= 1'b0;
        #1;
        chk(what, exp, rd_data_out);
    endtask
    task automatic pulse(input int k, input int ch);
        @(posedge clk_in);
        ev[k][ch] <= 1'b1;
        @(posedge clk_in);
        ev[k][ch] <= 1'b0;
        #1;
    endtask
    task automatic level(input int k, input int ch, input logic v);
        @(posedge clk_in);
        lv[k][ch] <= v;
        @(posedge clk_in);
        #1;
    endtask
    function automatic logic [7:0] mod_vec(input logic [7:0] v, input logic [2:0] c);
        mod_vec = v;
        mod_vec[VEC_CODE_LSB +: VEC_CODE_W] = c;
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(0, REG_VECTOR, 8'h00, "vector reset");
        rd(0, REG_XFER_MODE, 8'h00, "xfer mode read");
        rd(1, REG_EXT_ENABLE, 8'h00, "ext enable read");
        rd(0, 4'h5, 8'h00, "unmapped read");
        $display("test reset done");
        pulse(3, 0);
        rd(0, REG_PENDING, 8'h00, "pending while disabled");
        wr(0, REG_XFER_MODE, 8'h02);
        pulse(3, 0);
        rd(0, REG_PENDING, 8'h10, "pending tx a");
        rd(1, REG_PENDING, 8'h00, "pending via b");
        chk("int masked", 8'h01, {7'h0, int_line});
        wr(0, REG_MASTER, 8'h08);
        chk("int raised", 8'h00, {7'h0, int_line});
        chk("chain out busy", 8'h00, {7'h0, chain_enable_out});
        @(posedge clk_in);
        chain_enable_in <= 1'b0;
        #1;
        chk("int upstream busy", 8'h01, {7'h0, int_line});
        @(posedge clk_in);
        chain_enable_in <= 1'b1;
        $display("test enables done");
        wr(0, REG_VECTOR, 8'hF1);
        wr(1, REG_XFER_MODE, 8'h10);
        pulse(0, 1);
        rd(1, REG_VECTOR, mod_vec(8'hF1, CODE_A_TX), "vector b over tx a");
        wr(0, REG_XFER_MODE, 8'h12);
        pulse(0, 0);
        rd(0, REG_PENDING, 8'h34, "pending summary");
        rd(1, REG_VECTOR, mod_vec(8'hF1, CODE_A_RX), "vector b rx a");
        rd(0, REG_VECTOR, 8'hF1, "vector a raw");
        $display("test priority done");
        wr(0, REG_MASTER, 8'h09);
        u_host.do_ack(2, got);
        chk("ack vector", mod_vec(8'hF1, CODE_A_RX), got);
        rd(0, REG_COMMAND, 8'h01, "service rx a");
        pulse(2, 0);
        chk("int blocked", 8'h01, {7'h0, int_line});
        chk("chain out blocked", 8'h00, {7'h0, chain_enable_out});
        wr(0, REG_COMMAND, 8'h38);
        chk("int after service", 8'h00, {7'h0, int_line});
        $display("test hardware ack done");
        wr(0, REG_MASTER, 8'h2B);
        rd(1, REG_VECTOR, mod_vec(8'hF1, CODE_A_TX), "soft ack vector");
        rd(0, REG_COMMAND, 8'h02, "service tx a");
        wr(0, REG_COMMAND, 8'h28);
        chk("soft ack int", 8'h01, {7'h0, int_line});
        chk("soft ack chain", 8'h00, {7'h0, chain_enable_out});
        wr(0, REG_COMMAND, 8'h38);
        chk("int rx b", 8'h00, {7'h0, int_line});
        u_host.do_ack(0, got);
        chk("soft ack mode hw vector", 8'hF1, got);
        wr(0, REG_COMMAND, 8'h38);
        $display("test software ack done");
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wr(0, REG_XFER_MODE, 8'h08);
        pulse(1, 0);
        rd(0, REG_PENDING, 8'h00, "special before first");
        pulse(0, 0);
        rd(0, REG_PENDING, 8'h20, "first char");
        pulse(2, 0);
        pulse(0, 0);
        rd(0, REG_PENDING, 8'h00, "second char");
        pulse(1, 0);
        rd(0, REG_PENDING, 8'h20, "special after first");
        pulse(2, 0);
        wr(0, REG_XFER_MODE, 8'h18);
        pulse(0, 0);
        rd(0, REG_PENDING, 8'h00, "char in special mode");
        pulse(1, 0);
        wr(0, REG_MASTER, 8'h09);
        rd(1, REG_VECTOR, mod_vec(8'h00, CODE_A_SPEC), "special vector");
        pulse(2, 0);
        $display("test receive modes done");
        wr(0, REG_EXT_ENABLE, 8'hFA);
        wr(0, REG_XFER_MODE, 8'h01);
        // line changes first, then underrun and zero count pulses
        for (int k = 0; k < 6; k++) begin
            if (k < 4) begin
                level(k, 0, 1'b1);
            end else begin
                pulse(k, 0);
            end
            rd(0, REG_PENDING, 8'h08, "ext source");
            wr(0, REG_COMMAND, 8'h10);
        end
        level(3, 0, 1'b0);
        rd(0, REG_PENDING, 8'h08, "break end");
        wr(0, REG_COMMAND, 8'h10);
        rd(0, REG_PENDING, 8'h00, "ext cleared");
        $display("test ext status done");
        wr(0, REG_XFER_MODE, 8'hC0);
        @(posedge clk_in);
        tx_ready_in <= 2'h1;
        #1;
        chk("dma ready", 8'h02, {6'h0, wait_req_oe_out[0], wait_req_out[0]});
        @(posedge clk_in);
        tx_ready_in <= 2'h0;
        #1;
        chk("dma idle", 8'h03, {6'h0, wait_req_oe_out[0], wait_req_out[0]});
        wr(0, REG_XFER_MODE, 8'hE0);
        @(posedge clk_in);
        rx_ready_in <= 2'h1;
        #1;
        chk("dma rx ready", 8'h02, {6'h0, wait_req_oe_out[0], wait_req_out[0]});
        wr(0, REG_XFER_MODE, 8'h80);
        @(posedge clk_in);
        data_access_in <= 2'h1;
        #1;
        chk("cpu wait", 8'h02, {6'h0, wait_req_oe_out[0], wait_req_out[0]});
        $display("test wait request done");
        summarize();
    end
endmodule
